// *** verilog/tes_regs.svh ***
// Register indices, field positions, reset values and codes of the transmit edge shaper.
`ifndef TES_REGS_SVH
`define TES_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define TES_IDX_RES106      8'h14
`define TES_IDX_KIND        8'h15
`define TES_IDX_SHAPE       8'h16
`define TES_IDX_DUR         8'h17
`define TES_IDX_RES212      8'h18
`define TES_IDX_CTRL        8'h20
`define TES_IDX_ADAPT       8'h21
`define TES_IDX_LUTADR      8'h22
`define TES_IDX_LUTDAT      8'h23
`define TES_IDX_STATUS      8'h24

// Field positions.
`define TES_KIND_FALL_MSB   7
`define TES_KIND_FALL_LSB   4
`define TES_KIND_RISE_MSB   3
`define TES_KIND_RISE_LSB   0
`define TES_SHAPE_FALL_MSB  6
`define TES_SHAPE_FALL_LSB  4
`define TES_SHAPE_RISE_MSB  2
`define TES_SHAPE_RISE_LSB  0
`define TES_DUR_DOUBLE_BIT  7
`define TES_DUR_COUNT_MSB   4
`define TES_DUR_COUNT_LSB   0
`define TES_CTRL_EN_BIT     0
`define TES_CTRL_RATE_BIT   1
`define TES_SHAPE_MASK      8'h77
`define TES_DUR_MASK        8'h9f
`define TES_CTRL_MASK       8'h03

// Reset values.
`define TES_RST_RES106      8'h00
`define TES_RST_KIND        8'h11
`define TES_RST_SHAPE       8'h00
`define TES_RST_DUR         8'h08
`define TES_RST_RES212      8'h00
`define TES_RST_CTRL        8'h01
`define TES_RST_SUPREF      6'h20
`define TES_RST_CORR        8'h00

// Edge style codes.
`define TES_CODE_LIN1       4'h1
`define TES_CODE_LIN2       4'h2
`define TES_CODE_LIN3       4'h3
`define TES_CODE_LUT        4'h4
`define TES_CODE_LUT_CORR   4'h5
`define TES_CODE_LUT_ADAPT  4'h6
`define TES_LUT_MAX_TABLE   3'h3

// Amplitude and shaping constants.
`define TES_AMP_FULL        8'hff
`define TES_KNEE2           8'h80
`define TES_KNEE3A          8'h55
`define TES_KNEE3B          8'haa

// Bus answers.
`define TES_RESP_OKAY       2'b00
`define TES_RESP_SLVERR     2'b10

`endif

// *** verilog/tes_pkg.sv ***
// Types shared by the transmit edge shaper files.
package tes_pkg;

    typedef enum logic [1:0] {
        tes_st_idle = 2'b00,
        tes_st_fall = 2'b01,
        tes_st_low  = 2'b10,
        tes_st_rise = 2'b11
    } tes_state_type;

endpackage

// *** verilog/tes_edge_calc.sv ***
// Progress fraction of one edge for the current transition state.
`include "tes_regs.svh"

module tes_edge_calc import tes_pkg::*; #(
    parameter int CNT_W = 5
) (
    // Edge configuration
    input  wire logic [3:0]       style,
    input  wire logic [2:0]       cfg,
    input  wire logic [CNT_W-1:0] k,
    input  wire logic [CNT_W-1:0] count,
    // Table entry and supply adaptation
    input  wire logic [7:0]       lut_val,
    input  wire logic [5:0]       supply,
    input  wire logic [5:0]       supply_ref,
    input  wire logic [7:0]       corr,
    // Result
    output logic      [7:0]       frac,
    output logic                  legal
);

    logic [12:0] pnum;
    logic [7:0]  p;
    logic [7:0]  q;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [8:0]  t;
    logic [16:0] prod;
    logic [13:0] sc;
    logic [7:0]  adapted;
    logic [9:0]  withc;

    always_comb begin
        pnum    = 13'(k) * 13'h0ff;
        p       = (count == '0) ? `TES_AMP_FULL : 8'(pnum / 13'(count));
        q       = {cfg, 5'h1f};
        lo      = 8'h00;
        hi      = `TES_AMP_FULL;
        t       = {1'b0, p};
        sc      = (supply == 6'h00) ? 14'(lut_val) : 14'(14'(lut_val) * 14'(supply_ref) / 14'(supply));
        adapted = (sc > 14'h00ff) ? `TES_AMP_FULL : sc[7:0];
        withc   = 10'($signed({2'b00, adapted}) + $signed({{2{corr[7]}}, corr}));
        legal   = 1'b1;
        case (style)
            `TES_CODE_LIN2: begin
                if (p < `TES_KNEE2) begin
                    hi = q;
                    t  = {p, 1'b0};
                end else begin
                    lo = q;
                    t  = {8'(p - `TES_KNEE2), 1'b0};
                end
            end
            `TES_CODE_LIN3: begin
                if (p < `TES_KNEE3A) begin
                    hi = {1'b0, q[7:1]};
                    t  = 9'(p * 8'h03);
                end else if (p < `TES_KNEE3B) begin
                    lo = {1'b0, q[7:1]};
                    hi = q;
                    t  = 9'(8'(p - `TES_KNEE3A) * 8'h03);
                end else begin
                    lo = q;
                    t  = 9'(8'(p - `TES_KNEE3B) * 8'h03);
                end
            end
            default: begin
                t = {1'b0, p};
            end
        endcase
        if (t > 9'h0ff || p == `TES_AMP_FULL) begin
            t = 9'h0ff;
        end
        prod = 17'(8'(hi - lo)) * 17'(t) + 17'(8'(hi - lo));
        frac = 8'(lo + prod[15:8]);
        case (style)
            `TES_CODE_LIN1, `TES_CODE_LIN2, `TES_CODE_LIN3: begin
                legal = 1'b1;
            end
            `TES_CODE_LUT: begin
                frac  = lut_val;
                legal = (cfg <= `TES_LUT_MAX_TABLE);
            end
            `TES_CODE_LUT_CORR: begin
                // Correction is added after adaptation and clamped to the code range.
                frac  = withc[9] ? 8'h00 : (withc[8] ? `TES_AMP_FULL : withc[7:0]);
                legal = (cfg <= `TES_LUT_MAX_TABLE);
            end
            `TES_CODE_LUT_ADAPT: begin
                frac  = adapted;
                legal = (cfg <= `TES_LUT_MAX_TABLE);
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

endmodule

// *** verilog/tes_shaper.sv ***
// Transmit edge shaper for Type A reader mode with its register file on AXI4-Lite.
//
// The AXI4-Lite slave port was decided locally.
`include "tes_regs.svh"

module tes_shaper import tes_pkg::*; #(
    parameter int ADDR_W    = 12,
    parameter int CNT_W     = 5,
    parameter int LUT_TABLES = 4
) (
    // Clock, reset and enable
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // Write address channel
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // Write data channel
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // Write response channel
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // Read address channel
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // Read data channel
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Modulation request, carrier timing and supply level
    input  wire logic              mod_req,
    input  wire logic              carrier_tick,
    input  wire logic [5:0]        transmitter_supply_level,
    // Transmitter amplitude
    output logic [7:0]             tx_amplitude,
    output logic                   edge_active
);

    localparam int LUT_N = LUT_TABLES << CNT_W;
    localparam int LUT_A = $clog2(LUT_N);

    typedef struct packed {
        logic                  aw_full;
        logic [7:0]            aw_idx;
        logic                  w_full;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic [7:0]            res106;
        logic [7:0]            kind;
        logic [7:0]            shape;
        logic [7:0]            dur;
        logic [7:0]            res212;
        logic [7:0]            ctrl;
        logic [5:0]            sup_ref;
        logic [7:0]            corr;
        logic [LUT_A-1:0]      lut_adr;
        logic [LUT_N-1:0][7:0] lut;
        tes_state_type         st;
        logic [CNT_W-1:0]      k;
        logic                  half;
        logic [7:0]            amp;
        logic                  edge_act;
        logic                  bad_code;
    } tes_bundle_type;

    tes_bundle_type s_ff;
    tes_bundle_type nxt_s;

    logic [3:0]       fall_code;
    logic [3:0]       rise_code;
    logic [2:0]       fall_cfg;
    logic [2:0]       rise_cfg;
    logic [CNT_W-1:0] count;
    logic             dbl;
    logic [7:0]       res_sel;
    logic [7:0]       swing;
    logic [7:0]       fall_frac;
    logic [7:0]       rise_frac;
    logic             fall_legal;
    logic             rise_legal;
    logic             fall_ok;
    logic             rise_ok;
    logic [7:0]       fall_lut;
    logic [7:0]       rise_lut;
    logic [CNT_W-1:0] k_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration decode.

    assign fall_code = s_ff.kind[`TES_KIND_FALL_MSB:`TES_KIND_FALL_LSB];
    assign rise_code = s_ff.kind[`TES_KIND_RISE_MSB:`TES_KIND_RISE_LSB];
    assign fall_cfg  = s_ff.shape[`TES_SHAPE_FALL_MSB:`TES_SHAPE_FALL_LSB];
    assign rise_cfg  = s_ff.shape[`TES_SHAPE_RISE_MSB:`TES_SHAPE_RISE_LSB];
    assign count     = s_ff.dur[`TES_DUR_COUNT_MSB:`TES_DUR_COUNT_LSB];
    assign dbl       = s_ff.dur[`TES_DUR_DOUBLE_BIT];
    assign res_sel   = s_ff.ctrl[`TES_CTRL_RATE_BIT] ? s_ff.res212 : s_ff.res106;
    assign swing     = `TES_AMP_FULL - res_sel;
    assign k_prev    = s_ff.k - 1'b1;
    assign fall_lut  = s_ff.lut[{fall_cfg[1:0], k_prev}];
    assign rise_lut  = s_ff.lut[{rise_cfg[1:0], k_prev}];

    // Edges are shaped only at 106 kbit/s; the other rate steps straight to its level.
    assign fall_ok = s_ff.ctrl[`TES_CTRL_EN_BIT] && !s_ff.ctrl[`TES_CTRL_RATE_BIT]
                     && (count != '0) && fall_legal;
    assign rise_ok = s_ff.ctrl[`TES_CTRL_EN_BIT] && !s_ff.ctrl[`TES_CTRL_RATE_BIT]
                     && (count != '0) && rise_legal;

    tes_edge_calc #(
        .CNT_W (CNT_W)
    ) u_fall (
        .style      (fall_code),
        .cfg        (fall_cfg),
        .k          (s_ff.k),
        .count      (count),
        .lut_val    (fall_lut),
        .supply     (transmitter_supply_level),
        .supply_ref (s_ff.sup_ref),
        .corr       (s_ff.corr),
        .frac       (fall_frac),
        .legal      (fall_legal)
    );

    tes_edge_calc #(
        .CNT_W (CNT_W)
    ) u_rise (
        .style      (rise_code),
        .cfg        (rise_cfg),
        .k          (s_ff.k),
        .count      (count),
        .lut_val    (rise_lut),
        .supply     (transmitter_supply_level),
        .supply_ref (s_ff.sup_ref),
        .corr       (s_ff.corr),
        .frac       (rise_frac),
        .legal      (rise_legal)
    );

    // Portion of the swing reached at a fraction; a fraction of all ones gives the whole swing.
    function automatic logic [7:0] tes_scale(input logic [7:0] sw, input logic [7:0] f);
        logic [16:0] pr;
        pr = 17'(sw) * 17'(f) + 17'(sw);
        return pr[15:8];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register read multiplexer.

    function automatic logic [31:0] tes_read(input tes_bundle_type r, input logic [7:0] idx);
        case (idx)
            `TES_IDX_RES106: return {24'h000000, r.res106};
            `TES_IDX_KIND:   return {24'h000000, r.kind};
            `TES_IDX_SHAPE:  return {24'h000000, r.shape};
            `TES_IDX_DUR:    return {24'h000000, r.dur};
            `TES_IDX_RES212: return {24'h000000, r.res212};
            `TES_IDX_CTRL:   return {24'h000000, r.ctrl};
            `TES_IDX_ADAPT:  return {16'h0000, r.corr, 2'b00, r.sup_ref};
            `TES_IDX_LUTADR: return 32'(r.lut_adr);
            `TES_IDX_LUTDAT: return {24'h000000, r.lut[r.lut_adr]};
            `TES_IDX_STATUS: return {8'h00, r.amp, 3'b000, 5'(r.k), 4'h0, r.bad_code, r.edge_act, r.st};
            default:         return 32'h00000000;
        endcase
    endfunction

    function automatic logic tes_mapped(input logic [7:0] idx);
        case (idx)
            `TES_IDX_RES106, `TES_IDX_KIND, `TES_IDX_SHAPE, `TES_IDX_DUR, `TES_IDX_RES212,
            `TES_IDX_CTRL, `TES_IDX_ADAPT, `TES_IDX_LUTADR, `TES_IDX_LUTDAT, `TES_IDX_STATUS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: bus slave, register writes and edge sequencer.

    always_comb begin
        nxt_s = s_ff;

        // Address and data are accepted in either order; each ready drops until the response is taken.
        if (awvalid && s_ff.awready) begin
            nxt_s.aw_full = 1'b1;
            nxt_s.aw_idx  = awaddr[9:2];
            nxt_s.awready = 1'b0;
        end
        if (wvalid && s_ff.wready) begin
            nxt_s.w_full  = 1'b1;
            nxt_s.wdata   = wdata;
            nxt_s.wstrb   = wstrb;
            nxt_s.wready  = 1'b0;
        end
        if (s_ff.bvalid && bready) begin
            nxt_s.bvalid  = 1'b0;
            nxt_s.awready = 1'b1;
            nxt_s.wready  = 1'b1;
        end
        if (s_ff.aw_full && s_ff.w_full && !s_ff.bvalid) begin
            nxt_s.aw_full = 1'b0;
            nxt_s.w_full  = 1'b0;
            nxt_s.bvalid  = 1'b1;
            nxt_s.bresp   = tes_mapped(s_ff.aw_idx) ? `TES_RESP_OKAY : `TES_RESP_SLVERR;
            if (s_ff.wstrb[0]) begin
                case (s_ff.aw_idx)
                    `TES_IDX_RES106: nxt_s.res106 = s_ff.wdata[7:0];
                    `TES_IDX_KIND:   nxt_s.kind   = s_ff.wdata[7:0];
                    `TES_IDX_SHAPE:  nxt_s.shape  = s_ff.wdata[7:0] & `TES_SHAPE_MASK;
                    `TES_IDX_DUR:    nxt_s.dur    = s_ff.wdata[7:0] & `TES_DUR_MASK;
                    `TES_IDX_RES212: nxt_s.res212 = s_ff.wdata[7:0];
                    `TES_IDX_CTRL:   nxt_s.ctrl   = s_ff.wdata[7:0] & `TES_CTRL_MASK;
                    `TES_IDX_ADAPT:  nxt_s.sup_ref = s_ff.wdata[5:0];
                    `TES_IDX_LUTADR: nxt_s.lut_adr = s_ff.wdata[LUT_A-1:0];
                    `TES_IDX_LUTDAT: begin
                        // Auto-increment lets software stream a whole table with one address write.
                        nxt_s.lut[s_ff.lut_adr] = s_ff.wdata[7:0];
                        nxt_s.lut_adr           = s_ff.lut_adr + 1'b1;
                    end
                    default: begin
                        nxt_s.bresp = nxt_s.bresp;
                    end
                endcase
            end
            if (s_ff.wstrb[1] && s_ff.aw_idx == `TES_IDX_ADAPT) begin
                nxt_s.corr = s_ff.wdata[15:8];
            end
        end

        if (arvalid && s_ff.arready) begin
            nxt_s.arready = 1'b0;
            nxt_s.rvalid  = 1'b1;
            nxt_s.rdata   = tes_read(s_ff, araddr[9:2]);
            nxt_s.rresp   = tes_mapped(araddr[9:2]) ? `TES_RESP_OKAY : `TES_RESP_SLVERR;
        end
        if (s_ff.rvalid && rready) begin
            nxt_s.rvalid  = 1'b0;
            nxt_s.arready = 1'b1;
        end

        // A reserved code only ever leads to a hard step, never to an undefined envelope.
        nxt_s.bad_code = !fall_legal || !rise_legal;

        case (s_ff.st)
            tes_st_idle: begin
                nxt_s.amp = `TES_AMP_FULL;
                if (mod_req) begin
                    if (fall_ok) begin
                        nxt_s.st       = tes_st_fall;
                        nxt_s.k        = CNT_W'(1);
                        nxt_s.half     = 1'b0;
                        nxt_s.edge_act = 1'b1;
                    end else begin
                        nxt_s.st  = tes_st_low;
                        nxt_s.amp = res_sel;
                    end
                end
            end
            tes_st_fall: begin
                if (carrier_tick) begin
                    if (dbl && !s_ff.half) begin
                        nxt_s.half = 1'b1;
                    end else begin
                        nxt_s.half = 1'b0;
                        nxt_s.amp  = `TES_AMP_FULL - tes_scale(swing, fall_frac);
                        if (s_ff.k >= count) begin
                            nxt_s.st       = tes_st_low;
                            nxt_s.amp      = res_sel;
                            nxt_s.edge_act = 1'b0;
                        end else begin
                            nxt_s.k = s_ff.k + 1'b1;
                        end
                    end
                end
            end
            tes_st_low: begin
                nxt_s.amp = res_sel;
                if (!mod_req) begin
                    if (rise_ok) begin
                        nxt_s.st       = tes_st_rise;
                        nxt_s.k        = CNT_W'(1);
                        nxt_s.half     = 1'b0;
                        nxt_s.edge_act = 1'b1;
                    end else begin
                        nxt_s.st  = tes_st_idle;
                        nxt_s.amp = `TES_AMP_FULL;
                    end
                end
            end
            tes_st_rise: begin
                if (carrier_tick) begin
                    if (dbl && !s_ff.half) begin
                        nxt_s.half = 1'b1;
                    end else begin
                        nxt_s.half = 1'b0;
                        nxt_s.amp  = res_sel + tes_scale(swing, rise_frac);
                        if (s_ff.k >= count) begin
                            nxt_s.st       = tes_st_idle;
                            nxt_s.amp      = `TES_AMP_FULL;
                            nxt_s.edge_act = 1'b0;
                        end else begin
                            nxt_s.k = s_ff.k + 1'b1;
                        end
                    end
                end
            end
            default: begin
                nxt_s.st = tes_st_idle;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff         <= '0;
            s_ff.awready <= 1'b1;
            s_ff.wready  <= 1'b1;
            s_ff.arready <= 1'b1;
            s_ff.res106  <= `TES_RST_RES106;
            s_ff.kind    <= `TES_RST_KIND;
            s_ff.shape   <= `TES_RST_SHAPE;
            s_ff.dur     <= `TES_RST_DUR;
            s_ff.res212  <= `TES_RST_RES212;
            s_ff.ctrl    <= `TES_RST_CTRL;
            s_ff.sup_ref <= `TES_RST_SUPREF;
            s_ff.corr    <= `TES_RST_CORR;
            s_ff.st      <= tes_st_idle;
            s_ff.amp     <= `TES_AMP_FULL;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    assign awready      = s_ff.awready;
    assign wready       = s_ff.wready;
    assign bresp        = s_ff.bresp;
    assign bvalid       = s_ff.bvalid;
    assign arready      = s_ff.arready;
    assign rdata        = s_ff.rdata;
    assign rresp        = s_ff.rresp;
    assign rvalid       = s_ff.rvalid;
    assign tx_amplitude = s_ff.amp;
    assign edge_active  = s_ff.edge_act;

endmodule

// *** dv/tes_shaper_checker.sv ***
// Port checker for the transmit edge shaper.
module tes_shaper_checker (
    // Bus handshakes
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // Shaper
    input wire logic        ce,
    input wire logic        mod_req,
    input wire logic        carrier_tick,
    input wire logic        edge_active,
    input wire logic [7:0]  tx_amplitude
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_b_after_aw: assert property (awvalid && awready && wvalid && wready && ce |-> ##2 bvalid)
        else $error("write answer late");
    a_r_after_ar: assert property (arvalid && arready && ce |=> rvalid)
        else $error("read answer late");
    a_b_holds: assert property (bvalid && !bready |=> bvalid)
        else $error("write answer dropped");
    a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer changed");
    a_aw_blocked: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    a_edge_bounded: assert property ($rose(edge_active) |-> ##[1:1000] !edge_active)
        else $error("edge never ends");
    a_amp_hold: assert property (edge_active && $past(edge_active) && !carrier_tick |=> $stable(tx_amplitude))
        else $error("amplitude moved without tick");
    a_end_on_tick: assert property ($fell(edge_active) && $past(edge_active, 2) |-> $past(carrier_tick))
        else $error("edge ended without tick");
    a_idle_full: assert property ((!mod_req && !edge_active) [*3] |-> tx_amplitude == 8'hff)
        else $error("idle amplitude not full");
endmodule

bind tes_shaper tes_shaper_checker u_tes_shaper_checker (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .ce, .mod_req, .carrier_tick, .edge_active,
    .tx_amplitude);

// *** dv/tes_shaper_bench.sv ***
// Self-checking bench for the transmit edge shaper.
`include "tes_regs.svh"
module tes_shaper_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, mod_req, carrier_tick, took;
    logic        awready, wready, bvalid, arready, rvalid, edge_active;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp, tdiv;
    logic [5:0]  transmitter_supply_level;
    logic [7:0]  tx_amplitude;
    logic [7:0]  amp_log [0:255];
    int          n_mismatch, checks, n_tick, base;
    logic [23:0] regs [5] = '{24'h14_00ff, 24'h15_11ff, 24'h16_0077, 24'h17_089f, 24'h18_00ff};
    logic [23:0] cfgs [7] = '{24'h14_0040, 24'h16_0022, 24'h17_0002, 24'h22_0040, 24'h23_0080, 24'h21_1020,
                              24'h18_0033};
    logic [23:0] rows [7] = '{24'h11_20a0, 24'h22_20b9, 24'h33_20cb, 24'h44_109f, 24'h55_2093, 24'h66_1040,
                              24'h66_209f};

    tes_shaper u_tes_shaper (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .mod_req,
        .carrier_tick, .transmitter_supply_level, .tx_amplitude, .edge_active);

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // One carrier tick every fourth clock; amplitudes are logged after each tick taken by an edge.
    always @(posedge aclk) begin
        tdiv <= tdiv + 2'h1;
        carrier_tick <= (tdiv == 2'h3);
        took <= (edge_active === 1'b1) && carrier_tick;
        if (took) begin
            amp_log[n_tick[7:0]] <= tx_amplitude;
            n_tick <= n_tick + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        @(posedge aclk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx);
        @(posedge aclk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic run_edge(input logic lvl);
        int w;
        w = 0;
        @(posedge aclk);
        base = n_tick;
        mod_req <= lvl;
        while (edge_active !== 1'b1 && w < 8) begin
            @(posedge aclk);
            w++;
        end
        while (edge_active === 1'b1 && w < 400) begin
            @(posedge aclk);
            w++;
        end
        repeat (3) @(posedge aclk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, mod_req, took, tdiv, carrier_tick} = '0;
        {awaddr, araddr, wdata, n_tick, checks, n_mismatch} = '0;
        ce = 1'b1;
        wstrb = 4'hf;
        transmitter_supply_level = 6'h20;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i]) begin
            wr(regs[i][23:16], 16'h00ff);
            rd(regs[i][23:16]);
            check(rv, {24'h0, regs[i][7:0]});
        end
        foreach (cfgs[i]) wr(cfgs[i][23:16], cfgs[i][15:0]);
        foreach (rows[i]) begin
            wr(`TES_IDX_KIND, {8'h0, rows[i][23:16]});
            transmitter_supply_level <= rows[i][13:8];
            run_edge(1'b1);
            check(n_tick - base, 2);
            if (rows[i][7:0] != 8'h00) check({24'h0, amp_log[base]}, {24'h0, rows[i][7:0]});
            check({24'h0, amp_log[base + 1]}, 32'h40);
            run_edge(1'b0);
            check({24'h0, amp_log[base + 1]}, 32'hff);
        end
        wr(`TES_IDX_DUR, 16'h0082);
        run_edge(1'b1);
        check(n_tick - base, 4);
        check({24'h0, amp_log[base + 3]}, 32'h40);
        run_edge(1'b0);
        wr(`TES_IDX_CTRL, 16'h0003);
        run_edge(1'b1);
        check({24'h0, tx_amplitude}, 32'h33);
        run_edge(1'b0);
        wr(`TES_IDX_CTRL, 16'h0001);
        wr(`TES_IDX_KIND, 16'h0077);
        run_edge(1'b1);
        check({24'h0, tx_amplitude}, 32'h40);
        check(n_tick - base, 0);
        run_edge(1'b0);
        wr(8'h3f, 16'h0001);
        check({30'h0, resp}, 32'h2);
        rd(8'h3f);
        check(rv, 32'h0);
        ce <= 1'b0;
        mod_req <= 1'b1;
        repeat (3) @(posedge aclk);
        check({24'h0, tx_amplitude}, 32'hff);
        ce <= 1'b1;
        repeat (3) @(posedge aclk);
        check({24'h0, tx_amplitude}, 32'h40);
        aresetn <= 1'b0;
        mod_req <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check({23'h0, edge_active, tx_amplitude}, 32'hff);
        foreach (regs[i]) begin
            rd(regs[i][23:16]);
            check(rv, {24'h0, regs[i][15:8]});
        end
        report_and_stop();
    end

    initial begin
        #3000000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
